// ### port_cfg_pkg.sv
package port_cfg_pkg;
    typedef enum logic [1:0] {
        MODE_PACKET,
        MODE_SCRIPT,
        MODE_DISABLED
    } port_mode_e;
    localparam int CLK_HZ = 250_000_000;
    localparam int TICKS_PER_MS = CLK_HZ / 1000;
    localparam int NUM_TTL = 3;
    localparam int RATE_W = 20;
    localparam logic [RATE_W-1:0] UART_RATE_MIN = 20'd300;
    localparam logic [RATE_W-1:0] UART_RATE_MAX = 20'd1000000;
    localparam logic [RATE_W-1:0] UART_RATE_DEF = 20'd115200;
    localparam logic [3:0] CAN_RATE_IDX_DEF = 4'h3;
    localparam int CAN_RATES = 9;
    localparam logic [6:0] CAN_NODE_IDENTIFIER_MIN = 7'h01;
    localparam logic [6:0] CAN_NODE_IDENTIFIER_MAX = 7'h7F;
    localparam logic [6:0] CAN_NODE_IDENTIFIER_DEF = 7'h01;
    localparam logic [1:0] I2C_RATE_DEF = 2'h0;
    localparam logic [1:0] I2C_RATE_MAX_IDX = 2'h2;
    localparam logic [15:0] TIMEOUT_MS_DEF = 16'h0000;
    // CAN rates by index, fastest first
    localparam logic [RATE_W-1:0] CAN_RATE_TAB [CAN_RATES] = '{
        20'd1000000, 20'd800000, 20'd500000, 20'd250000, 20'd125000,
        20'd100000, 20'd50000, 20'd20000, 20'd10000};
    localparam logic [RATE_W-1:0] I2C_RATE_TAB [3] = '{
        20'd100000, 20'd400000, 20'd1000000};
endpackage

// ### control_port_config_mux.sv
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Any received byte restarts port priority timeout
// (RULE2) Expired timeout hands control to next priority
// (RULE3) USB offers packet and script modes, timeout
// (RULE4) Host RTS forces USB packet mode
// (RULE5) CAN uses nine rates, default 250000
// (RULE6) CAN can_node_identifier accepts only 1..127
// (RULE7) CAN has no timeout, runs at any priority
// (RULE8) CAN pins high impedance when CAN unused
// (RULE9) Serial rates 300..1000000, default 115200
// (RULE10) I2C master rate 100k, 400k or 1M
// (RULE11) I2C reachable only from script engine
// (RULE12) Script mode routes UART data to script
// (RULE13) Three TTL UARTs with own settings
// (RULE14) Multi-unit mode makes TX open drain
// (RULE15) Far side pulls up shared RX line
// (RULE16) Muxed digital inputs only when UART disabled
// (RULE17) Each pin carries only its mode's function
// (RULE18) Reset restores default rates and modes
module control_port_config_mux
    import port_cfg_pkg::*;
#(
    parameter int N_SRC = 5, // USB, RS-232, three TTL
    parameter int TICKS_MS = TICKS_PER_MS // Clocks per ms, below 2**18
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst_b, // Async reset, low
    input wire logic i_cfg_we, // Config write strobe
    input wire logic [2:0] i_cfg_port, // 0 USB,1 RS232,2..4 TTL
    input wire port_mode_e i_cfg_mode, // Port mode
    input wire logic [RATE_W-1:0] i_cfg_rate, // Serial rate bps
    input wire logic [15:0] i_cfg_timeout_ms, // Priority timeout
    input wire logic i_cfg_multi, // Multi-unit option
    input wire logic i_can_we, // CAN config strobe
    input wire logic i_can_en, // CANopen selected
    input wire logic [3:0] i_can_rate_idx, // CAN rate index
    input wire logic [6:0] i_can_node, // CAN can_node_identifier
    input wire logic i_i2c_we, // I2C rate strobe (script)
    input wire logic [1:0] i_i2c_rate_idx, // I2C rate index
    input wire logic i_usb_rts, // Host RTS (async)
    input wire logic [N_SRC-1:0] i_rx_valid, // Byte received
    input wire logic [N_SRC-1:0] i_rx_data, // Serial rx level
    input wire logic [N_SRC-1:0] i_tx_data, // Transmit level
    input wire logic [1:0] i_din_pin, // Pins of UART2/3 (async)
    input wire logic i_can_tx, // CAN controller tx
    output logic [N_SRC-1:0] o_to_parser, // Data to packet parser
    output logic [N_SRC-1:0] o_to_script, // Data to script engine
    output logic [N_SRC-1:0] o_tx_out, // TX pin level
    output logic [N_SRC-1:0] o_tx_oe, // TX pin drive enable
    output logic [N_SRC-1:0] o_timed_out, // Priority lost
    output logic [2:0] o_active_src, // Controlling source
    output logic o_usb_packet, // USB in packet mode
    output logic [RATE_W-1:0] o_can_rate, // CAN rate bps
    output logic [6:0] o_can_node, // CAN can_node_identifier
    output logic o_can_tx, // CAN pin out
    output logic o_can_oe, // CAN pin enable
    output logic [RATE_W-1:0] o_i2c_rate, // I2C rate bps
    output logic [1:0] o_din // Muxed digital inputs
);
    ////////////////////////////////////////////////////////////////////
    port_mode_e mode_ff [N_SRC];
    logic [RATE_W-1:0] rate_ff [N_SRC];
    logic [15:0] tmo_ff [N_SRC];
    logic [N_SRC-1:0] multi_ff;
    logic [3:0] can_idx_ff;
    logic [6:0] node_ff;
    logic [1:0] i2c_idx_ff;
    logic rts_s1_ff, rts_s2_ff;
    logic [1:0] din_s1_ff, din_s2_ff;
    logic [17:0] ms_cnt_ff;
    logic ms_tick;

    function automatic logic rate_ok(input logic [RATE_W-1:0] r);
        rate_ok = (r >= UART_RATE_MIN) && (r <= UART_RATE_MAX);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Per-port settings; out-of-range writes are ignored
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_port
            logic sel;
            assign sel = i_cfg_we && (i_cfg_port == 3'(g));
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    mode_ff[g] <= MODE_PACKET; // [RULE18]
                    rate_ff[g] <= UART_RATE_DEF; // [RULE9]
                    tmo_ff[g] <= TIMEOUT_MS_DEF;
                    multi_ff[g] <= 1'b0;
                end else if (sel) begin // [RULE13]
                    // USB and RS-232 have no disabled mode [RULE3]
                    if (i_cfg_mode != MODE_DISABLED || g >= 2)
                        mode_ff[g] <= i_cfg_mode;
                    if (rate_ok(i_cfg_rate))
                        rate_ff[g] <= i_cfg_rate; // [RULE9]
                    tmo_ff[g] <= i_cfg_timeout_ms;
                    if (g >= 2)
                        multi_ff[g] <= i_cfg_multi;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            can_idx_ff <= CAN_RATE_IDX_DEF; // [RULE5]
            node_ff <= CAN_NODE_IDENTIFIER_DEF;
        end else if (i_can_we) begin
            if (i_can_rate_idx < 4'(CAN_RATES))
                can_idx_ff <= i_can_rate_idx; // [RULE5]
            if (i_can_node >= CAN_NODE_IDENTIFIER_MIN && i_can_node <= CAN_NODE_IDENTIFIER_MAX)
                node_ff <= i_can_node; // [RULE6]
        end
    end

    // Only the script engine drives this strobe [RULE11]
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            i2c_idx_ff <= I2C_RATE_DEF;
        else if (i_i2c_we && i_i2c_rate_idx <= I2C_RATE_MAX_IDX)
            i2c_idx_ff <= i_i2c_rate_idx; // [RULE10]
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rts_s1_ff <= 1'b0;
            rts_s2_ff <= 1'b0;
            din_s1_ff <= 2'b00;
            din_s2_ff <= 2'b00;
        end else begin
            rts_s1_ff <= i_usb_rts;
            rts_s2_ff <= rts_s1_ff;
            din_s1_ff <= i_din_pin;
            din_s2_ff <= din_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Millisecond tick for timeouts
    assign ms_tick = (ms_cnt_ff == 18'(TICKS_MS - 1));
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            ms_cnt_ff <= '0;
        else
            ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + 18'd1;
    end

    // Timeout counters; zero timeout means never expire
    logic [15:0] ms_left_ff [N_SRC];
    generate
        for (g = 0; g < N_SRC; g++) begin : g_tmo
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    ms_left_ff[g] <= TIMEOUT_MS_DEF;
                    o_timed_out[g] <= 1'b0;
                end else if (i_rx_valid[g]) begin // [RULE1]
                    ms_left_ff[g] <= tmo_ff[g];
                    o_timed_out[g] <= 1'b0;
                end else if (ms_tick && tmo_ff[g] != 16'h0000) begin
                    if (ms_left_ff[g] != 16'h0000)
                        ms_left_ff[g] <= ms_left_ff[g] - 16'd1;
                    else
                        o_timed_out[g] <= 1'b1; // [RULE2]
                end
            end
        end
    endgenerate

    // Lowest index that has not timed out holds control [RULE2]
    // CAN is outside this chain: no timeout [RULE7]
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_active_src <= 3'h0;
        end else begin
            o_active_src <= 3'(N_SRC);
            for (int i = N_SRC - 1; i >= 0; i--)
                if (!o_timed_out[i])
                    o_active_src <= 3'(i);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data routing and TX drive
    generate
        for (g = 0; g < N_SRC; g++) begin : g_route
            logic pkt;
            // RTS forces USB packet mode [RULE4]
            assign pkt = (mode_ff[g] == MODE_PACKET) || (g == 0 && rts_s2_ff);
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_to_parser[g] <= 1'b0;
                    o_to_script[g] <= 1'b0;
                    o_tx_out[g] <= 1'b1;
                    o_tx_oe[g] <= 1'b0;
                end else begin
                    o_to_parser[g] <= pkt && i_rx_data[g];
                    o_to_script[g] <= !pkt && mode_ff[g] == MODE_SCRIPT
                                      && i_rx_data[g]; // [RULE12]
                    if (!pkt && mode_ff[g] == MODE_DISABLED) begin
                        o_tx_out[g] <= 1'b1; // [RULE17]
                        o_tx_oe[g] <= 1'b0;
                    end else if (multi_ff[g]) begin
                        o_tx_out[g] <= 1'b0; // [RULE14]
                        o_tx_oe[g] <= !i_tx_data[g];
                    end else begin
                        o_tx_out[g] <= i_tx_data[g];
                        o_tx_oe[g] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            o_usb_packet <= 1'b1;
        else
            o_usb_packet <= mode_ff[0] == MODE_PACKET || rts_s2_ff; // [RULE4]
    end

    // Digital inputs on TTL2/TTL3 pins only when that UART disabled
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_din <= 2'b00;
        end else begin
            o_din[0] <= mode_ff[3] == MODE_DISABLED && din_s2_ff[0]; // [RULE16]
            o_din[1] <= mode_ff[4] == MODE_DISABLED && din_s2_ff[1]; // [RULE16]
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_can_tx <= 1'b1;
            o_can_oe <= 1'b0;
            o_can_rate <= CAN_RATE_TAB[CAN_RATE_IDX_DEF];
            o_can_node <= CAN_NODE_IDENTIFIER_DEF;
            o_i2c_rate <= I2C_RATE_TAB[I2C_RATE_DEF];
        end else begin
            o_can_oe <= i_can_en; // [RULE8]
            o_can_tx <= i_can_en ? i_can_tx : 1'b1;
            o_can_rate <= CAN_RATE_TAB[can_idx_ff]; // [RULE5]
            o_can_node <= node_ff;
            o_i2c_rate <= I2C_RATE_TAB[i2c_idx_ff]; // [RULE10]
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_rts_force;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        rts_s2_ff |=> o_usb_packet;
    endproperty
    a_rts_force: assert property (p_rts_force) else $error("rts no pkt"); // [RULE4]
    property p_node_range;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        o_can_node >= CAN_NODE_IDENTIFIER_MIN;
    endproperty
    a_node_range: assert property (p_node_range) else $error("bad node"); // [RULE6]
    property p_can_hiz;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !i_can_en |=> !o_can_oe;
    endproperty
    a_can_hiz: assert property (p_can_hiz) else $error("can driven"); // [RULE8]
    property p_rx_restart;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_rx_valid[0] |=> !o_timed_out[0];
    endproperty
    a_rx_restart: assert property (p_rx_restart) else $error("no restart"); // [RULE1]
    property p_din_gate;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        mode_ff[3] != MODE_DISABLED && $stable(mode_ff[3]) |=> !o_din[0];
    endproperty
    a_din_gate: assert property (p_din_gate) else $error("din leak"); // [RULE16]
    property p_multi_od;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        o_tx_oe[2] && multi_ff[2] && $stable(multi_ff[2]) |-> !o_tx_out[2];
    endproperty
    a_multi_od: assert property (p_multi_od) else $error("od high"); // [RULE14]
    property p_uart_rate;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        rate_ff[2] >= UART_RATE_MIN && rate_ff[2] <= UART_RATE_MAX;
    endproperty
    a_uart_rate: assert property (p_uart_rate) else $error("rate range"); // [RULE9]
    property p_script_excl;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !(o_to_parser[1] && o_to_script[1]);
    endproperty
    a_script_excl: assert property (p_script_excl) else $error("both paths"); // [RULE12]
    c_timeout: cover property (@(posedge i_core_clk) o_timed_out[0]);
    c_rts: cover property (@(posedge i_core_clk) rts_s2_ff);
    c_can: cover property (@(posedge i_core_clk) o_can_oe);
endmodule // control_port_config_mux

// ### host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
    input wire logic i_core_clk, // Core clock
    input wire logic [4:0] i_tx_out, // Device TX level
    input wire logic [4:0] i_tx_oe, // Device TX enable
    output logic [4:0] o_rx_valid, // Byte strobe
    output logic [4:0] o_rx_data, // Line level
    output logic o_rts, // Request to send
    output logic [4:0] o_line // Host RX line
);
    // Host pull-up: a released line reads high
    assign o_line = i_tx_out | ~i_tx_oe;
    initial begin
        o_rx_valid = '0;
        o_rx_data = '1;
        o_rts = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic send(input logic [2:0] p, input logic lvl);
        @(negedge i_core_clk);
        o_rx_data[p] = lvl;
        o_rx_valid[p] = 1'b1;
        @(negedge i_core_clk);
        o_rx_valid[p] = 1'b0;
    endtask
    task automatic set_rts(input logic v);
        @(negedge i_core_clk);
        o_rts = v;
    endtask
endmodule // host_link_model

// ### control_port_config_mux_tb.sv
`timescale 1ns/1ps
module control_port_config_mux_tb;
    import port_cfg_pkg::*;
    logic clk = 0, rst_b = 0, cfg_we = 0, cfg_multi = 0, can_we = 0;
    logic can_en = 0, i2c_we = 0, can_tx_in = 0, usb_packet, can_tx, can_oe;
    logic [2:0] cfg_port = 0, active_src;
    port_mode_e cfg_mode = MODE_PACKET;
    logic [3:0] can_idx = 4'h3;
    logic [6:0] can_node = 7'h01, node_out;
    logic [1:0] i2c_idx = 2'h0, din_pin = 2'h0, din;
    logic [4:0] tx_data = 5'h04, rx_valid, rx_data, to_parser, to_script;
    logic [4:0] tx_out, tx_oe, timed_out, line;
    logic [19:0] can_rate, i2c_rate, cfg_rate = 20'd115200;
    logic [15:0] cfg_tmo = 16'h0000;
    logic rts;
    int error_cnt = 0, num_checks = 0;
    always #2 clk = ~clk;
    // Short millisecond so priority timeouts fit the run
    control_port_config_mux #(.TICKS_MS(8)) dut (.i_core_clk(clk),
        .i_rst_b(rst_b),
        .i_cfg_we(cfg_we), .i_cfg_port(cfg_port), .i_cfg_mode(cfg_mode),
        .i_cfg_rate(cfg_rate), .i_cfg_timeout_ms(cfg_tmo),
        .i_cfg_multi(cfg_multi), .i_can_we(can_we), .i_can_en(can_en),
        .i_can_rate_idx(can_idx), .i_can_node(can_node), .i_i2c_we(i2c_we),
        .i_i2c_rate_idx(i2c_idx), .i_usb_rts(rts), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .i_tx_data(tx_data), .i_din_pin(din_pin),
        .i_can_tx(can_tx_in), .o_to_parser(to_parser), .o_to_script(to_script),
        .o_tx_out(tx_out), .o_tx_oe(tx_oe), .o_timed_out(timed_out),
        .o_active_src(active_src), .o_usb_packet(usb_packet),
        .o_can_rate(can_rate), .o_can_node(node_out), .o_can_tx(can_tx),
        .o_can_oe(can_oe), .o_i2c_rate(i2c_rate), .o_din(din));
    host_link_model host (.i_core_clk(clk), .i_tx_out(tx_out),
        .i_tx_oe(tx_oe), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .o_rts(rts), .o_line(line));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cfg(input logic [2:0] pt, port_mode_e m, logic mu);
        @(negedge clk);
        cfg_port = pt;
        cfg_mode = m;
        cfg_multi = mu;
        cfg_we = 1'b1;
        @(negedge clk);
        cfg_we = 1'b0;
        wt(3);
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(can_rate, 20'd250000);
        chk(20'(node_out), 20'h0_0001);
        chk(i2c_rate, 20'd100000);
        chk(20'({usb_packet, can_oe}), 20'h0_0002);
        chk(20'({timed_out, active_src}), 20'h0_0000);
    endtask
    task automatic t_rates();
        logic [19:0] ct [9] = '{20'd1000000, 20'd800000, 20'd500000,
            20'd250000, 20'd125000, 20'd100000, 20'd50000, 20'd20000, 20'd10000};
        logic [19:0] it [3] = '{20'd100000, 20'd400000, 20'd1000000};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            can_idx = 4'(i);
            can_node = (i == 9) ? 7'h00 : 7'(127 - i);
            i2c_idx = 2'(i);
            can_we = 1'b1;
            i2c_we = (i < 4);
            @(negedge clk);
            can_we = 1'b0;
            i2c_we = 1'b0;
            wt(2);
            chk(can_rate, ct[(i == 9) ? 8 : i]);
            chk(20'(node_out), 20'(127 - ((i == 9) ? 8 : i)));
            chk(i2c_rate, it[(i > 2) ? 2 : i]);
        end
    endtask
    task automatic t_can_pins();
        @(negedge clk);
        can_idx = 4'h3;
        can_en = 1'b1;
        can_we = 1'b1;
        @(negedge clk);
        can_we = 1'b0;
        for (int v = 0; v < 2; v++) begin
            can_tx_in = v[0];
            wt(3);
            chk(20'({can_oe, can_tx}), {18'h0, 1'b1, v[0]});
        end
        can_en = 1'b0;
        can_we = 1'b1;
        @(negedge clk);
        can_we = 1'b0;
        wt(3);
        chk(20'({can_oe, can_tx}), 20'h0_0001);
    endtask
    task automatic t_route();
        // Rate below minimum must leave the stored rate alone
        cfg_rate = 20'd299;
        cfg(3'h2, MODE_SCRIPT, 1'b0);
        cfg_rate = 20'd115200;
        host.send(3'h2, 1'b0);
        wt(3);
        chk(20'(to_script[2]), 20'h0_0000);
        host.send(3'h2, 1'b1);
        wt(3);
        chk(20'(to_script[2]), 20'h0_0001);
        chk(20'(to_parser[2]), 20'h0_0000);
        cfg(3'h2, MODE_PACKET, 1'b0);
        host.send(3'h2, 1'b1);
        wt(3);
        chk(20'({to_parser[2], to_script[2]}), 20'h0_0002);
    endtask
    task automatic t_multi();
        cfg(3'h4, MODE_PACKET, 1'b1);
        tx_data[4] = 1'b0;
        wt(3);
        chk(20'({tx_oe[4], tx_out[4], line[4]}), 20'h0_0004);
        tx_data[4] = 1'b1;
        wt(3);
        chk(20'({tx_oe[4], line[4]}), 20'h0_0001);
        chk(20'({tx_oe[2], tx_out[2]}), 20'h0_0003);
    endtask
    task automatic t_din();
        cfg(3'h3, MODE_DISABLED, 1'b0);
        din_pin = 2'b01;
        wt(4);
        chk(20'(din[0]), 20'h0_0001);
        chk(20'(din[1]), 20'h0_0000);
        chk(20'({tx_oe[3], tx_out[3]}), 20'h0_0001);
        din_pin = 2'b10;
        wt(4);
        chk(20'(din[0]), 20'h0_0000);
        chk(20'(din[1]), 20'h0_0000);
        // RS-232 has no disabled mode: it stays in packet mode
        cfg(3'h1, MODE_DISABLED, 1'b0);
        host.send(3'h1, 1'b1);
        wt(3);
        chk(20'(to_parser[1]), 20'h0_0001);
    endtask
    task automatic t_rts();
        cfg(3'h0, MODE_SCRIPT, 1'b0);
        host.send(3'h0, 1'b1);
        wt(3);
        chk(20'({usb_packet, to_script[0]}), 20'h0_0001);
        host.set_rts(1'b1);
        wt(4);
        chk(20'(usb_packet), 20'h0_0001);
        chk(20'({to_parser[0], to_script[0]}), 20'h0_0002);
        host.set_rts(1'b0);
        wt(4);
        chk(20'({usb_packet, to_script[0]}), 20'h0_0001);
    endtask
    task automatic t_timeout();
        cfg_tmo = 16'h0001;
        cfg(3'h0, MODE_PACKET, 1'b0);
        cfg_tmo = 16'h0000;
        host.send(3'h0, 1'b1);
        wt(4);
        chk(20'({timed_out[0], active_src}), 20'h0_0000);
        // Two ticks at most without data, then control moves on
        wt(20);
        chk(20'({timed_out[0], active_src}), 20'h0_0009);
        host.send(3'h0, 1'b1);
        wt(3);
        chk(20'({timed_out[0], active_src}), 20'h0_0000);
        cfg(3'h0, MODE_PACKET, 1'b0);
    endtask
    task automatic t_mid_reset();
        @(negedge clk);
        rst_b = 1'b0;
        wt(2);
        rst_b = 1'b1;
        wt(1);
        t_reset();
        chk(20'({tx_oe[4], tx_out[4]}), 20'h0_0003);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        wt(5);
        rst_b = 1'b1;
        wt(1);
        t_reset();
        t_rates();
        t_can_pins();
        t_route();
        t_multi();
        t_din();
        t_timeout();
        t_rts();
        t_mid_reset();
        complete_run();
    end
endmodule // control_port_config_mux_tb
